// ==== logic/mode_ctrl.v ====
/*
 * Chip mode transition controller with APB register file, per-mode
 * configuration, interrupts and peripheral clock gating.
 * Assumes reset generation, failure and wakeup inputs come from logic on pclk.
 */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "mode_ctrl_consts.vh"

module mode_ctrl #(
    parameter NPERIPH = 8
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // System events, all from internal logic; no device pins [R16]
    input wire sys_reset_active,
    input wire resources_ready,
    input wire safe_clk_req,
    input wire hw_failure,
    input wire wake_irq,
    input wire wake_event,
    // Mode outputs
    output reg [3:0] current_mode,
    output reg [31:0] active_cfg,
    output reg [3:0] sys_clk_sel,
    output reg core_clk_en,
    output reg sw_running,
    output reg [NPERIPH-1:0] periph_clk_en,
    output wire irq
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg [3:0] target_mode;
    reg pending;
    reg [15:0] mode_enable;
    reg [3:0] int_status;
    reg [3:0] int_mask;
    reg [3:0] inv_status;
    reg [31:0] mode_cfg [0:15];
    reg [7:0] run_pc [0:7];
    reg [7:0] lp_pc [0:7];
    reg [7:0] pctl [0:NPERIPH-1];
    reg key_ok;
    integer i;
    integer j;

    wire access = psel & penable & clk_en;
    wire wr = access & pwrite;
    wire [11:0] a = paddr;
    wire is_cfg = (a[11:6] == 6'h00) & (a[5:2] >= 4'h8) & (a[5:2] != 4'hF);
    wire is_run = (a[11:5] == 7'h04);
    wire is_lp = (a[11:5] == 7'h05);
    wire is_pctl = (a[11:2] >= 10'h030) & (a[11:2] < (10'h030 + NPERIPH / 4));
    wire is_ps = (a == `OFS_PERIPH_STATUS);
    wire is_ro = (a == `OFS_GLOBAL_STATUS) | is_ps;
    wire is_rw = (a == `OFS_MODE_CONTROL) | (a == `OFS_MODE_ENABLE)
        | (a == `OFS_INT_STATUS) | (a == `OFS_INT_MASK)
        | (a == `OFS_INVALID_STATUS) | is_cfg | is_run | is_lp | is_pctl;
    wire err = ~(is_ro | is_rw) | (pwrite & is_ro); // [R17]
    wire do_wr = wr & ~err; // [R17]
    wire [3:0] cfg_idx = a[5:2] - 4'h8;

    assign pready = 1'b1;
    assign pslverr = psel & penable & err; // [R17]
    assign irq = |(int_status & int_mask); // [R13]

    // ------------------------------------------------------------------------
    // Software request legality
    // ------------------------------------------------------------------------
    wire mctl_wr = do_wr & (a == `OFS_MODE_CONTROL);
    wire [3:0] req = pwdata[31:28];
    wire req_user = (req >= `MODE_RUN0) & (req <= `MODE_RUN3);
    wire cur_user = (current_mode >= `MODE_RUN0) & (current_mode <= `MODE_RUN3);
    reg legal;
    always @* begin
        case (current_mode)
            `MODE_STARTUP_RUN_MODE: legal = req_user | (req == `MODE_TEST) | (req == `MODE_SAFE)
                | (req == `MODE_STARTUP_RUN_MODE); // [R3] [R4] [R5]
            `MODE_TEST: legal = (req == `MODE_STARTUP_RUN_MODE); // [R4]
            `MODE_SAFE: legal = (req == `MODE_STARTUP_RUN_MODE); // [R6]
            `MODE_RUN0, 4'h5, 4'h6, `MODE_RUN3: legal = req_user | (req == `MODE_STARTUP_RUN_MODE)
                | (req == `MODE_SAFE) | (req == `MODE_HALT)
                | (req == `MODE_STOP); // [R7] [R8] [R10]
            default: legal = 1'b0;
        endcase
    end
    wire bad_key = (pwdata[15:0] != `MCTL_KEY) & (pwdata[15:0] != `MCTL_KEY_INV);
    wire disabled = ~mode_enable[req]; // [R15]

    // ------------------------------------------------------------------------
    // Mode machine and register writes
    // ------------------------------------------------------------------------
    wire lp_mode = (current_mode == `MODE_HALT) | (current_mode == `MODE_STOP);
    wire wake = (current_mode == `MODE_HALT) ? wake_irq : (wake_irq | wake_event);
    reg [3:0] next_mode;
    reg next_event;
    reg [3:0] next_inv;

    always @* begin
        next_mode = current_mode;
        next_event = 1'b0;
        next_inv = 4'h0;
        if (current_mode == `MODE_RESET) begin
            if (!sys_reset_active && resources_ready) begin
                next_mode = `MODE_STARTUP_RUN_MODE; // [R1] [R2]
            end
        end else if (hw_failure && current_mode != `MODE_SAFE
                     && current_mode != `MODE_TEST) begin
            next_mode = `MODE_SAFE; // [R5] [R9] [R10]
        end else if (lp_mode && wake) begin
            next_mode = target_mode; // [R7] [R9] [R10]
        end else if (mctl_wr && pwdata[15:0] == `MCTL_KEY) begin
            if (bad_key) next_inv[`INV_BADKEY] = 1'b1;
            else if (disabled) next_inv[`INV_DISABLED] = 1'b1; // [R19]
            else if (!legal) next_inv[`INV_ILLEGAL] = 1'b1; // [R19]
            else next_mode = req;
        end else if (mctl_wr && pwdata[15:0] == `MCTL_KEY_INV) begin
            next_inv = 4'h0;
        end else if (mctl_wr) begin
            next_inv[`INV_BADKEY] = 1'b1; // [R12]
        end
        next_event = (next_mode != current_mode);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_mode <= `MODE_RESET; // [R1]
            target_mode <= `MODE_RUN0;
            pending <= 1'b0;
            key_ok <= 1'b0;
            mode_enable <= `MODE_ENABLE_RST;
            int_status <= 4'h0;
            int_mask <= 4'h0;
            inv_status <= 4'h0;
            for (i = 0; i < 16; i = i + 1) mode_cfg[i] <= `MODE_CFG_RST;
            for (i = 0; i < 8; i = i + 1) begin
                run_pc[i] <= 8'h00;
                lp_pc[i] <= 8'h00;
            end
            for (i = 0; i < NPERIPH; i = i + 1) pctl[i] <= 8'h00;
        end else if (clk_en) begin
            if (sys_reset_active) begin
                current_mode <= `MODE_RESET; // [R1] [R4] [R6]
            end else begin
                current_mode <= next_mode;
            end
            if (mctl_wr && !bad_key) target_mode <= lp_mode ? target_mode
                : (req_user ? req : target_mode);
            if (lp_mode == 1'b0 && cur_user) target_mode <= current_mode;
            pending <= 1'b0;
            key_ok <= 1'b0;
            // Hardware set wins over a software clear in the same cycle.
            int_status <= (do_wr && a == `OFS_INT_STATUS ? int_status & ~pwdata[3:0]
                : int_status)
                | {next_inv != 4'h0, 1'b0, next_mode == `MODE_SAFE && next_event,
                   next_event}; // [R13]
            inv_status <= (do_wr && a == `OFS_INVALID_STATUS
                ? inv_status & ~pwdata[3:0] : inv_status) | next_inv; // [R12]
            if (do_wr && a == `OFS_MODE_ENABLE) begin
                // Reset, startup, safe and test are always available.
                mode_enable <= pwdata[15:0] | `MODE_ENABLE_RST; // [R15]
            end
            if (do_wr && a == `OFS_INT_MASK) int_mask <= pwdata[3:0];
            if (do_wr && is_cfg && cfg_idx != `MODE_RESET) mode_cfg[cfg_idx] <= pwdata;
            if (do_wr && is_run) run_pc[a[4:2]] <= pwdata[7:0];
            if (do_wr && is_lp) lp_pc[a[4:2]] <= pwdata[7:0];
            if (do_wr && is_pctl) begin
                for (i = 0; i < NPERIPH; i = i + 1) begin
                    if (a[11:2] == 10'h030 + i / 4) pctl[i] <= pwdata[8*(i%4) +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode-derived outputs and peripheral gating
    // ------------------------------------------------------------------------
    reg [NPERIPH-1:0] next_pclk;
    reg [2:0] sel;
    always @* begin
        sel = 3'h0;
        for (j = 0; j < NPERIPH; j = j + 1) begin
            sel = lp_mode ? pctl[j][5:3] : pctl[j][2:0];
            if (lp_mode) next_pclk[j] = lp_pc[sel][current_mode[3:1] & 3'h7]; // [R14]
            else next_pclk[j] = run_pc[sel][current_mode[2:0]]; // [R14]
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_cfg <= `CFG_SAFE_VALUE;
            sys_clk_sel <= 4'h0;
            core_clk_en <= 1'b0;
            sw_running <= 1'b0;
            periph_clk_en <= {NPERIPH{1'b0}};
        end else if (clk_en) begin
            active_cfg <= (current_mode == `MODE_SAFE) ? `CFG_SAFE_VALUE
                : mode_cfg[current_mode]; // [R5]
            sys_clk_sel <= (safe_clk_req || current_mode == `MODE_SAFE)
                ? 4'h0 : mode_cfg[current_mode][3:0]; // [R18]
            core_clk_en <= ~lp_mode & (current_mode != `MODE_RESET); // [R8] [R10]
            sw_running <= ~lp_mode & (current_mode != `MODE_RESET); // [R11]
            periph_clk_en <= (current_mode == `MODE_RESET) ? {NPERIPH{1'b0}} : next_pclk;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        case (1'b1)
            a == `OFS_GLOBAL_STATUS: prdata = {current_mode, 3'b000, pending,
                8'h00, resources_ready, safe_clk_req, core_clk_en, sw_running,
                sys_clk_sel, target_mode, 4'h0}; // [R15]
            a == `OFS_MODE_CONTROL: prdata = {target_mode, 12'h000, `MCTL_KEY};
            a == `OFS_MODE_ENABLE: prdata = {16'h0000, mode_enable};
            a == `OFS_INT_STATUS: prdata = {28'h0, int_status};
            a == `OFS_INT_MASK: prdata = {28'h0, int_mask};
            a == `OFS_INVALID_STATUS: prdata = {28'h0, inv_status};
            is_cfg: prdata = mode_cfg[cfg_idx];
            is_ps: prdata = {{(32-NPERIPH){1'b0}}, periph_clk_en}; // [R14]
            is_run: prdata = {24'h0, run_pc[a[4:2]]};
            is_lp: prdata = {24'h0, lp_pc[a[4:2]]};
            default: prdata = 32'h0000_0000;
        endcase
    end

endmodule

// ==== logic/mode_ctrl_consts.vh ====
/*
 * Constants for the chip mode transition controller: register offsets,
 * mode codes, field positions and reset values.
 * Assumes inclusion by the controller module only; definitions only.
 */
// Function
// R1 - Reset assertion enters virtual reset mode; stays until all resources ready.
// R2 - Reset deassertion moves the chip to the startup run mode.
// R3 - Only startup mode opens user modes; safe, test, user may return to it.
// R4 - Test mode entered only from startup; leaves only to startup or reset.
// R5 - Failure or software request from startup/user enters safe mode, safe config.
// R6 - Safe mode leaves only by software to startup, or by reset.
// R7 - User modes entered by software, or from low-power on interrupt or wakeup.
// R8 - Light sleep entered only from user mode; core clock stopped.
// R9 - Light sleep exits on interrupt to run, on failure to safe, or reset.
// R10 - Deep sleep entered from run mode; exits on interrupt, wakeup, failure, reset.
// R11 - Only startup, safe, test and user modes run software.
// R12 - Each invalid transition cause has its own status bit.
// R13 - Mode transition events raise maskable interrupts.
// R14 - Peripheral clocks gated by per-mode run and low-power sets; status readable.
// R15 - Mode enable register limits modes; global status shows mode and resources.
// R16 - No external pins are driven or sampled.
// R17 - Unused address or read-only write changes nothing and signals an error.
// R18 - Safe clock request forces the internal oscillator as system clock.
// R19 - Disabled or illegal software request is rejected and flagged.
`ifndef MODE_CTRL_CONSTS_VH
`define MODE_CTRL_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_GLOBAL_STATUS 12'h000
`define OFS_MODE_CONTROL 12'h004
`define OFS_MODE_ENABLE 12'h008
`define OFS_INT_STATUS 12'h00C
`define OFS_INT_MASK 12'h010
`define OFS_INVALID_STATUS 12'h014
`define OFS_MODE_CFG_BASE 12'h020
`define OFS_PERIPH_STATUS 12'h060
`define OFS_RUN_PC_BASE 12'h080
`define OFS_LP_PC_BASE 12'h0A0
`define OFS_PCTL_BASE 12'h0C0

// ----------------------------------------------------------------------------
// Mode codes (also index of the per-mode configuration word)
// ----------------------------------------------------------------------------
`define MODE_RESET 4'h0
`define MODE_TEST 4'h1
`define MODE_SAFE 4'h2
`define MODE_STARTUP_RUN_MODE 4'h3
`define MODE_RUN0 4'h4
`define MODE_RUN3 4'h7
`define MODE_HALT 4'h8
`define MODE_STOP 4'hA

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MCTL_KEY 16'h5AF0
`define MCTL_KEY_INV 16'hA50F
`define MODE_ENABLE_RST 16'h000F
`define MODE_CFG_RST 32'h0000_0010
`define CFG_CORE_CLK_OFF 16
`define CFG_SAFE_VALUE 32'h0000_0000
`define IRQ_TRANSITION 0
`define IRQ_SAFE 1
`define IRQ_INVALID 3
`define INV_DISABLED 0
`define INV_ILLEGAL 1
`define INV_BUSY 2
`define INV_BADKEY 3

`endif

// ==== tb/mode_ctrl_sva.sv ====
/* Port assertions for the mode controller.
   Assumes it is bound into mode_ctrl from the bench top file. */
`timescale 1ns/1ps
module mode_ctrl_sva (
    // Clock, reset and bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    // Events and mode outputs
    input wire sys_reset_active,
    input wire resources_ready,
    input wire safe_clk_req,
    input wire hw_failure,
    input wire [3:0] current_mode,
    input wire [31:0] active_cfg,
    input wire [3:0] sys_clk_sel,
    input wire core_clk_en,
    input wire sw_running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence held(logic [3:0] m);
        current_mode == m ##1 current_mode == m;
    endsequence
    sequence entered(logic [3:0] m);
        $changed(current_mode) && current_mode == m;
    endsequence
    reset_entry_a: assert property (sys_reset_active |-> ##[0:1] current_mode == 4'h0)
        else $error("mode did not return to reset");
    reset_hold_a: assert property (current_mode == 4'h0 && !resources_ready |=> current_mode == 4'h0)
        else $error("reset mode left before resources ready");
    test_entry_a: assert property (entered(4'h1) |-> $past(current_mode) == 4'h3)
        else $error("test mode entered from wrong mode");
    test_exit_a: assert property ($past(current_mode) == 4'h1 && current_mode != 4'h1
        |-> current_mode inside {4'h0, 4'h3})
        else $error("test mode left to wrong mode");
    safe_exit_a: assert property ($past(current_mode) == 4'h2 && current_mode != 4'h2
        |-> current_mode inside {4'h0, 4'h3})
        else $error("safe mode left to wrong mode");
    user_entry_a: assert property ($changed(current_mode) && current_mode inside {[4'h4:4'h7]}
        |-> $past(current_mode) inside {[4'h3:4'h8], 4'hA})
        else $error("user mode entered from wrong mode");
    sleep_entry_a: assert property ($changed(current_mode) && current_mode inside {4'h8, 4'hA}
        |-> $past(current_mode) inside {[4'h4:4'h7]})
        else $error("sleep mode entered from wrong mode");
    fail_safe_a: assert property (hw_failure && !sys_reset_active
        && current_mode inside {[4'h3:4'h8], 4'hA} |-> ##[1:2] current_mode == 4'h2)
        else $error("failure did not enter safe mode");
    safe_cfg_a: assert property (held(4'h2) |-> active_cfg == 32'h0000_0000)
        else $error("safe configuration not applied");
    core_off_a: assert property (held(4'h8) or held(4'hA) |-> !core_clk_en && !sw_running)
        else $error("core clock running in sleep");
    sw_run_a: assert property ((current_mode inside {[4'h1:4'h7]})[*2] |-> sw_running)
        else $error("software flag low in running mode");
    safe_clk_a: assert property (safe_clk_req[*2] |-> sys_clk_sel == 4'h0)
        else $error("safe clock request not obeyed");
    bus_err_a: assert property (psel && penable && (paddr == 12'h018 || pwrite && paddr == 12'h000)
        |-> pslverr && pready)
        else $error("bad access not refused");
endmodule

// ==== tb/rgu_model.sv ====
/* Model of the reset generation unit and event sources.
   Assumes the bench calls its tasks just after a rising pclk edge. */
`timescale 1ns/1ps
module rgu_model (
    // Clock
    input wire pclk,
    // Lines into the controller
    output logic sys_reset_active = 1'b1,
    output logic resources_ready = 1'b0,
    output logic safe_clk_req = 1'b1,
    output logic hw_failure = 1'b0,
    output logic wake_irq = 1'b0,
    output logic wake_event = 1'b0
);
    task boot(input int slow);
        sys_reset_active <= 1'b1;
        resources_ready <= 1'b0;
        safe_clk_req <= 1'b1;
        repeat (2) @(posedge pclk);
        sys_reset_active <= 1'b0;
        repeat (slow) @(posedge pclk);
        resources_ready <= 1'b1;
        safe_clk_req <= 1'b0;
    endtask
    task fail();
        hw_failure <= 1'b1;
        safe_clk_req <= 1'b1;
        repeat (3) @(posedge pclk);
        hw_failure <= 1'b0;
        safe_clk_req <= 1'b0;
    endtask
    task wake(input logic ev);
        wake_irq <= !ev;
        wake_event <= ev;
        repeat (3) @(posedge pclk);
        wake_irq <= 1'b0;
        wake_event <= 1'b0;
    endtask
endmodule

// ==== tb/tb_top.sv ====
/* Self-checking bench for the mode controller with a mode model.
   Assumes mode_ctrl, rgu_model and mode_ctrl_sva are compiled first. */
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, active_cfg;
    logic pready, pslverr, irq, core_clk_en, sw_running;
    logic sys_reset_active, resources_ready, safe_clk_req, hw_failure, wake_irq, wake_event;
    logic [3:0] current_mode, sys_clk_sel;
    logic [7:0] periph_clk_en;
    int fails = 0, n_tests = 0, mode = 0, last_user = 4, msk = 0, t, i, n;
    int en[16] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    int tbl[9] = '{1, 2, 3, 4, 5, 6, 7, 8, 10};
    always #50 pclk = ~pclk;
    mode_ctrl mode_ctrl_i (.*);
    rgu_model rgu_model_i (.*);
    // ------------------------------------------------------------------
    // Checking, bus and model tasks
    // ------------------------------------------------------------------
    task summarize;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            fails++;
            summarize();
        end
        // Answer is taken at the edge that completes the access phase.
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function int legal(int c, int g);
        case (c)
            3: return g inside {1, 2, [4:7]};
            1, 2: return g == 3;
            4, 5, 6, 7: return g inside {2, 3, [4:8], 10};
            default: return 0;
        endcase
    endfunction
    task settle();
        for (i = 0; i < 6 && current_mode !== mode[3:0]; i++) @(posedge pclk);
        chk("mode", current_mode, mode);
        apb(0, 12'h000, 0);
        chk("status_mode", rd[31:28], mode);
    endtask
    task req(input int g);
        int e, ok;
        ok = legal(mode, g) && en[g];
        e = !en[g] ? 1 : (ok ? 0 : 2);
        apb(1, 12'h004, {g[3:0], 12'h000, 16'h5AF0});
        if (ok) mode = g;
        if (ok && g inside {[4:7]}) last_user = g;
        settle();
        chk("irq", irq, (e != 0 && msk[3]) || (ok && msk[0]));
        apb(0, 12'h014, 0);
        chk("invalid", rd & 32'h0000_0003, e);
        apb(1, 12'h014, 32'h0000_000F);
        apb(1, 12'h00C, 32'h0000_000F);
        chk("irq_clr", irq, 0);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        t = $urandom(40);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        fork
            rgu_model_i.boot(8);
            begin repeat (5) @(posedge pclk); chk("wait", current_mode, 0); end
        join
        mode = 3;
        settle();
        apb(0, 12'h008, 0); chk("enable_rst", rd, 32'h0000_000F);
        apb(0, 12'h02C, 0); chk("cfg_rst", rd, 32'h0000_0010);
        apb(1, 12'h000, 0); chk("ro_err", err, 1);
        apb(0, 12'h018, 0); chk("hole_err", err, 1);
        apb(0, 12'h000, 0); chk("ok_err", err, 0);
        apb(0, 12'h008, 0); chk("unchanged", rd, 32'h0000_000F);
        msk = 8; apb(1, 12'h010, 32'h0000_0008);
        req(4);
        apb(1, 12'h008, 32'h0000_05FF);
        for (i = 4; i < 11; i++) en[i] = (i != 9);
        for (n = 0; n < 80; n++) begin
            if (n == 60) begin
                msk = 1;
                apb(1, 12'h010, 32'h0000_0001);
                apb(1, 12'h00C, 32'h0000_000F);
            end
            if (mode inside {8, 10}) begin
                rgu_model_i.wake(mode == 10 && $urandom % 2);
                mode = last_user;
                settle();
                apb(1, 12'h00C, 32'h0000_000F);
            end else if ($urandom % 8 == 0) begin
                rgu_model_i.fail();
                if (mode != 1) mode = 2;
                settle();
                apb(1, 12'h00C, 32'h0000_000F);
            end else begin
                do t = tbl[$urandom % 9]; while (t == mode);
                req(t);
            end
        end
        rgu_model_i.boot(3);
        mode = 3;
        settle();
        summarize();
    end
endmodule
bind mode_ctrl mode_ctrl_sva mode_ctrl_sva_i (.*);
